// >>> shared/sesum_pkg.sv
// Shared constants, types and command encodings of the status event summary block
package sesum_pkg;

  // ----------------------------------------------------------------
  // Group sizes and indices
  // ----------------------------------------------------------------
  localparam int SESUM_GRP_WIDTH = 16;
  localparam int SESUM_STB_WIDTH = 8;
  localparam int SESUM_NUM_GRPS = 3;
  localparam int SESUM_GRP_STD = 0;
  localparam int SESUM_GRP_OPER = 1;
  localparam int SESUM_GRP_QUES = 2;

  // ----------------------------------------------------------------
  // Per group layout and reset values (index order: std, oper, ques)
  // ----------------------------------------------------------------
  localparam logic [15:0] SESUM_USED_MASK [SESUM_NUM_GRPS] = '{16'h00ff, 16'h7fff, 16'h7fff};
  localparam logic [15:0] SESUM_RISE_DEFAULT [SESUM_NUM_GRPS] = '{16'h00ff, 16'h7fff, 16'h7fff};
  localparam logic [15:0] SESUM_FALL_DEFAULT [SESUM_NUM_GRPS] = '{16'h0000, 16'h0000, 16'h0000};
  localparam logic [15:0] SESUM_ENABLE_DEFAULT [SESUM_NUM_GRPS] = '{16'h0000, 16'h0000, 16'h0000};
  localparam bit SESUM_FILTER_RW [SESUM_NUM_GRPS] = '{1'b0, 1'b1, 1'b1};
  localparam logic [15:0] SESUM_COND_DEFAULT = 16'h0000;
  localparam logic [15:0] SESUM_EVENT_DEFAULT = 16'h0000;

  // ----------------------------------------------------------------
  // Status byte bit positions
  // ----------------------------------------------------------------
  localparam int SESUM_SB_INST_LSB = 0;
  localparam int SESUM_SB_INST_MSB = 2;
  localparam int SESUM_SB_QUES = 3;
  localparam int SESUM_SB_MAV = 4;
  localparam int SESUM_SB_ESB = 5;
  localparam int SESUM_SB_RQS = 6;
  localparam int SESUM_SB_OPR = 7;
  localparam logic [7:0] SESUM_SRE_DEFAULT = 8'h00;
  localparam logic [7:0] SESUM_STB_DEFAULT = 8'h00;

  // ----------------------------------------------------------------
  // Standard event bit positions
  // ----------------------------------------------------------------
  localparam int SESUM_SE_QUERY_ERR = 2;
  localparam int SESUM_SE_DEV_ERR = 3;
  localparam int SESUM_SE_EXEC_ERR = 4;
  localparam int SESUM_SE_CMD_ERR = 5;

  // ----------------------------------------------------------------
  // Command encodings
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SESUM_TGT_COMMON = 2'b00,
    SESUM_TGT_OPER = 2'b01,
    SESUM_TGT_QUES = 2'b10
  } sesum_tgt_t;

  typedef enum logic [3:0] {
    SESUM_ACT_EVENT_RD = 4'h0,
    SESUM_ACT_ENABLE_WR = 4'h1,
    SESUM_ACT_ENABLE_RD = 4'h2,
    SESUM_ACT_COND_RD = 4'h3,
    SESUM_ACT_RISE_WR = 4'h4,
    SESUM_ACT_RISE_RD = 4'h5,
    SESUM_ACT_FALL_WR = 4'h6,
    SESUM_ACT_FALL_RD = 4'h7,
    SESUM_ACT_CLS = 4'h8,
    SESUM_ACT_RST = 4'h9,
    SESUM_ACT_SRE_WR = 4'ha,
    SESUM_ACT_SRE_RD = 4'hb,
    SESUM_ACT_STB_RD = 4'hc
  } sesum_act_t;

  typedef struct packed {
    logic valid;
    sesum_tgt_t tgt;
    sesum_act_t act;
    logic [15:0] data;
  } sesum_cmd_t;

  typedef struct packed {
    logic valid;
    logic error;
    logic [15:0] data;
  } sesum_resp_t;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } sesum_poll_t;

endpackage : sesum_pkg

// >>> hdl/sesum_group.sv
// One status group: condition, edge filters, latched events, enable mask and summary
`timescale 1ns/1ps
module sesum_group import sesum_pkg::*; #(
  parameter int WIDTH = 16,
  parameter logic [WIDTH-1:0] USED_MASK = '1,
  parameter logic [WIDTH-1:0] RISE_DEFAULT = '1,
  parameter logic [WIDTH-1:0] FALL_DEFAULT = '0,
  parameter logic [WIDTH-1:0] ENABLE_DEFAULT = '0,
  parameter bit FILTER_RW = 1'b1
) (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Monitored status
  input wire logic [WIDTH-1:0] cond_in,
  // Control strobes
  input wire logic clear_events,
  input wire logic load_filter_defaults,
  input wire logic wr_enable,
  input wire logic wr_rising,
  input wire logic wr_falling,
  input wire logic [WIDTH-1:0] wdata,
  // Register contents
  output logic [WIDTH-1:0] cond_r,
  output logic [WIDTH-1:0] event_r,
  output logic [WIDTH-1:0] enable_r,
  output logic [WIDTH-1:0] rising_edge_filter,
  output logic [WIDTH-1:0] falling_edge_filter,
  output logic summary
);

  logic [WIDTH-1:0] hit;
  logic [WIDTH-1:0] event_nxt;

  // ----------------------------------------------------------------
  // Condition tracking
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      cond_r <= WIDTH'(SESUM_COND_DEFAULT);
    end else begin
      cond_r <= cond_in & USED_MASK; // [R1] [R10]
    end
  end

  // ----------------------------------------------------------------
  // Edge filters
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (sys_rst || load_filter_defaults) begin
      rising_edge_filter <= RISE_DEFAULT & USED_MASK; // [R3]
      falling_edge_filter <= FALL_DEFAULT & USED_MASK; // [R3]
    end else if (FILTER_RW) begin
      if (wr_rising) begin
        rising_edge_filter <= wdata & USED_MASK; // [R3]
      end
      if (wr_falling) begin
        falling_edge_filter <= wdata & USED_MASK; // [R3]
      end
    end
  end

  assign hit = ((cond_in & ~cond_r & rising_edge_filter) |
                (~cond_in & cond_r & falling_edge_filter)) & USED_MASK; // [R2] [R4]

  // ----------------------------------------------------------------
  // Event latch, set wins over clear
  // ----------------------------------------------------------------
  assign event_nxt = (clear_events ? '0 : event_r) | hit; // [R5] [R6] [R24]

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      event_r <= WIDTH'(SESUM_EVENT_DEFAULT);
    end else begin
      event_r <= event_nxt; // [R5]
    end
  end

  // ----------------------------------------------------------------
  // Enable mask and summary
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      enable_r <= ENABLE_DEFAULT & USED_MASK;
    end else if (wr_enable) begin
      enable_r <= wdata & USED_MASK; // [R8]
    end
  end

  assign summary = |(event_r & enable_r); // [R7]

endmodule : sesum_group

// >>> hdl/sesum_top.sv
// Status event summary block: three status groups, status byte and service request
// ----------------------------------------------------------------
// How it works
// [R1] Condition registers mirror live status each cycle, read only.
// [R2] Per-bit filters pass rising, falling or both transitions into events.
// [R3] Filters read/write; kept by clear and queries; defaults on reset command.
// [R4] Group without filter commands keeps fixed rising-only filter.
// [R5] Event bits latch until their read or clear-status; read only.
// [R6] Extra transitions on an already set event bit are ignored.
// [R7] Group summary is OR of event AND enable bits.
// [R8] Enable masks read/write; untouched by clear-status and by queries.
// [R9] Each group holds condition, filter, event and enable stages.
// [R10] Operation/questionable 16 bits with bit 15 zero; byte groups 8 bits.
// [R11] Command data are binary weights of bits, e.g. 4 is bit 2.
// [R12] Status byte summary rising raises the service request output.
// [R13] Serial poll returns request flag in bit 6, then clears it.
// [R14] Status query returns live master summary in bit 6, flag kept.
// [R15] Bits 0-5 and 7 identical for serial poll and status query.
// [R16] Bit 3 questionable, bit 5 standard event, bit 7 operation summary.
// [R17] Bit 4 set while output queue holds a message.
// [R18] Controller must read the causing event register to get more requests.
// [R19] Standard event group exposes only event and enable registers.
// [R20] Standard enable of 48 passes execution and command errors.
// [R21] Operation group offers condition, event and enable over status commands.
// [R22] Standard event bits: 5 command, 4 execution, 3 device, 2 query errors.
// [R23] No new request until the flag is cleared by serial poll.
// [R24] Transition coinciding with clearing read leaves the event bit set.
// ----------------------------------------------------------------
`timescale 1ns/1ps
module sesum_top import sesum_pkg::*; #(
  parameter int INST_BITS = 3
) (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Status sources
  input wire logic [15:0] oper_cond_in,
  input wire logic [15:0] ques_cond_in,
  input wire logic [7:0] std_event_in,
  input wire logic message_available_bit,
  input wire logic [INST_BITS-1:0] inst_status_in,
  // Command port from the message parser
  input wire sesum_cmd_t cmd_in,
  output sesum_resp_t resp_r,
  // Serial poll from the bus interface
  input wire logic poll_rd,
  output sesum_poll_t poll_r,
  // Service request toward the bus controller
  output logic request_service_flag
);

  logic [15:0] cond_src [SESUM_NUM_GRPS];
  logic [15:0] grp_cond [SESUM_NUM_GRPS];
  logic [15:0] grp_event [SESUM_NUM_GRPS];
  logic [15:0] grp_enable [SESUM_NUM_GRPS];
  logic [15:0] grp_rise [SESUM_NUM_GRPS];
  logic [15:0] grp_fall [SESUM_NUM_GRPS];
  logic [SESUM_NUM_GRPS-1:0] grp_summary;
  logic [SESUM_NUM_GRPS-1:0] grp_clear;
  logic [SESUM_NUM_GRPS-1:0] grp_wr_enable;
  logic [SESUM_NUM_GRPS-1:0] grp_wr_rise;
  logic [SESUM_NUM_GRPS-1:0] grp_wr_fall;
  logic cmd_cls;
  logic cmd_rst;
  logic cmd_common;
  logic [7:0] sre_r;
  logic [7:0] stb_base;
  logic master_summary;
  logic mss_prev_r;
  logic rqs_nxt;
  int sel;
  sesum_resp_t resp_nxt;

  // ----------------------------------------------------------------
  // Command decode helpers
  // ----------------------------------------------------------------
  function automatic int tgt_group(input sesum_tgt_t tgt);
    unique case (tgt)
      SESUM_TGT_COMMON: tgt_group = SESUM_GRP_STD;
      SESUM_TGT_OPER: tgt_group = SESUM_GRP_OPER;
      SESUM_TGT_QUES: tgt_group = SESUM_GRP_QUES;
      default: tgt_group = -1;
    endcase
  endfunction : tgt_group

  function automatic logic hits(input sesum_cmd_t c, input int g, input sesum_act_t a);
    hits = c.valid && (tgt_group(c.tgt) == g) && (c.act == a);
  endfunction : hits

  assign sel = tgt_group(cmd_in.tgt);
  // Refused commands with a group target must have no effect
  assign cmd_common = cmd_in.valid && (cmd_in.tgt == SESUM_TGT_COMMON);
  assign cmd_cls = cmd_common && (cmd_in.act == SESUM_ACT_CLS); // [R5]
  assign cmd_rst = cmd_common && (cmd_in.act == SESUM_ACT_RST); // [R3]

  // ----------------------------------------------------------------
  // Status groups
  // ----------------------------------------------------------------
  assign cond_src[SESUM_GRP_STD] = {8'h00, std_event_in}; // [R19] [R22]
  assign cond_src[SESUM_GRP_OPER] = oper_cond_in; // [R21]
  assign cond_src[SESUM_GRP_QUES] = ques_cond_in;

  generate
    for (genvar g = 0; g < SESUM_NUM_GRPS; g++) begin : g_grp
      assign grp_clear[g] = cmd_cls || hits(cmd_in, g, SESUM_ACT_EVENT_RD); // [R5]
      assign grp_wr_enable[g] = hits(cmd_in, g, SESUM_ACT_ENABLE_WR); // [R8] [R20]
      assign grp_wr_rise[g] = hits(cmd_in, g, SESUM_ACT_RISE_WR);
      assign grp_wr_fall[g] = hits(cmd_in, g, SESUM_ACT_FALL_WR);

      // All four stages exist even where no command reaches them
      sesum_group #(
        .WIDTH(SESUM_GRP_WIDTH),
        .USED_MASK(SESUM_USED_MASK[g]),
        .RISE_DEFAULT(SESUM_RISE_DEFAULT[g]),
        .FALL_DEFAULT(SESUM_FALL_DEFAULT[g]),
        .ENABLE_DEFAULT(SESUM_ENABLE_DEFAULT[g]),
        .FILTER_RW(SESUM_FILTER_RW[g])
      ) u_grp ( // [R9] [R10]
        .clock(clock),
        .sys_rst(sys_rst),
        .cond_in(cond_src[g]),
        .clear_events(grp_clear[g]),
        .load_filter_defaults(cmd_rst),
        .wr_enable(grp_wr_enable[g]),
        .wr_rising(grp_wr_rise[g]),
        .wr_falling(grp_wr_fall[g]),
        .wdata(cmd_in.data), // [R11]
        .cond_r(grp_cond[g]),
        .event_r(grp_event[g]),
        .enable_r(grp_enable[g]),
        .rising_edge_filter(grp_rise[g]),
        .falling_edge_filter(grp_fall[g]),
        .summary(grp_summary[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Status byte enable mask
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      sre_r <= SESUM_SRE_DEFAULT;
    end else if (cmd_common && (cmd_in.act == SESUM_ACT_SRE_WR)) begin
      sre_r <= cmd_in.data[7:0] & ~(8'h01 << SESUM_SB_RQS); // [R11]
    end
  end

  // ----------------------------------------------------------------
  // Status byte assembly and master summary
  // ----------------------------------------------------------------
  always_comb begin
    stb_base = SESUM_STB_DEFAULT;
    stb_base[SESUM_SB_INST_MSB:SESUM_SB_INST_LSB] = inst_status_in[2:0];
    stb_base[SESUM_SB_QUES] = grp_summary[SESUM_GRP_QUES]; // [R16]
    stb_base[SESUM_SB_MAV] = message_available_bit; // [R17]
    stb_base[SESUM_SB_ESB] = grp_summary[SESUM_GRP_STD]; // [R16]
    stb_base[SESUM_SB_OPR] = grp_summary[SESUM_GRP_OPER]; // [R16]
  end

  assign master_summary = |(stb_base & sre_r); // [R7] [R14]

  // ----------------------------------------------------------------
  // Request service flag
  // ----------------------------------------------------------------
  always_comb begin
    rqs_nxt = request_service_flag;
    // Set wins: a poll that finds the flag low must not swallow a new request
    if (master_summary && !mss_prev_r && !request_service_flag) begin
      rqs_nxt = 1'b1; // [R12] [R23]
    end else if (poll_rd) begin
      rqs_nxt = 1'b0; // [R13]
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      mss_prev_r <= 1'b0;
      request_service_flag <= 1'b0;
    end else begin
      mss_prev_r <= master_summary;
      request_service_flag <= rqs_nxt; // [R12] [R13] [R23]
    end
  end

  // ----------------------------------------------------------------
  // Serial poll answer
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      poll_r <= '0;
    end else begin
      poll_r.valid <= poll_rd;
      if (poll_rd) begin
        poll_r.data <= stb_base; // [R15]
        poll_r.data[SESUM_SB_RQS] <= request_service_flag; // [R13]
      end
    end
  end

  // ----------------------------------------------------------------
  // Command answer
  // ----------------------------------------------------------------
  always_comb begin
    resp_nxt = '0;
    resp_nxt.valid = cmd_in.valid;
    if (cmd_in.valid) begin
      unique case (cmd_in.act)
        SESUM_ACT_CLS, SESUM_ACT_RST, SESUM_ACT_SRE_WR: begin
          resp_nxt.error = (cmd_in.tgt != SESUM_TGT_COMMON);
        end
        SESUM_ACT_SRE_RD, SESUM_ACT_STB_RD: begin
          resp_nxt.error = (cmd_in.tgt != SESUM_TGT_COMMON);
          if (cmd_in.act == SESUM_ACT_SRE_RD) begin
            resp_nxt.data = {8'h00, sre_r};
          end else begin
            resp_nxt.data = {8'h00, stb_base}; // [R15]
            resp_nxt.data[SESUM_SB_RQS] = master_summary; // [R14]
          end
        end
        SESUM_ACT_EVENT_RD, SESUM_ACT_ENABLE_WR, SESUM_ACT_ENABLE_RD: begin
          resp_nxt.error = (sel < 0);
          if (sel >= 0 && cmd_in.act == SESUM_ACT_EVENT_RD) begin
            resp_nxt.data = grp_event[sel]; // [R5] [R11]
          end else if (sel >= 0 && cmd_in.act == SESUM_ACT_ENABLE_RD) begin
            resp_nxt.data = grp_enable[sel]; // [R8]
          end
        end
        SESUM_ACT_COND_RD, SESUM_ACT_RISE_WR, SESUM_ACT_RISE_RD,
        SESUM_ACT_FALL_WR, SESUM_ACT_FALL_RD: begin
          // Standard event group hides its condition and filter
          resp_nxt.error = (sel <= SESUM_GRP_STD); // [R19]
          if (sel > SESUM_GRP_STD) begin
            if (cmd_in.act == SESUM_ACT_COND_RD) begin
              resp_nxt.data = grp_cond[sel]; // [R1]
            end else if (cmd_in.act == SESUM_ACT_RISE_RD) begin
              resp_nxt.data = grp_rise[sel]; // [R3]
            end else if (cmd_in.act == SESUM_ACT_FALL_RD) begin
              resp_nxt.data = grp_fall[sel]; // [R3]
            end
          end
        end
        default: begin
          resp_nxt.error = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      resp_r <= '0;
    end else begin
      resp_r <= resp_nxt;
    end
  end

endmodule : sesum_top

// >>> verif/sesum_ctrl_model.sv
// Bus controller model that serial-polls the block when a request is raised
`timescale 1ns/1ps
module sesum_ctrl_model import sesum_pkg::*; #(
  parameter int POLL_DELAY = 10
) (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Service request link
  input wire logic request_service_flag,
  input wire sesum_poll_t poll_r,
  output logic poll_rd = 1'b0,
  // Observation
  output logic [7:0] last_stb,
  output int poll_count
);
  int wait_cnt;

  always @(posedge clock) begin
    if (sys_rst) begin
      poll_rd <= 1'b0;
      wait_cnt <= 0;
      last_stb <= 8'h00;
      poll_count <= 0;
    end else begin
      poll_rd <= 1'b0;
      if (poll_r.valid) begin
        last_stb <= poll_r.data;
        poll_count <= poll_count + 1;
      end
      if (request_service_flag && !poll_rd) begin
        wait_cnt <= wait_cnt + 1;
        if (wait_cnt >= POLL_DELAY) begin
          poll_rd <= 1'b1; // Acknowledge; bench then reads the causing event reg
          wait_cnt <= 0;
        end
      end else begin
        wait_cnt <= 0;
      end
    end
  end
endmodule : sesum_ctrl_model

// >>> verif/sesum_top_assertions.sv
// Port checker of the status event summary block
`timescale 1ns/1ps
module sesum_checker import sesum_pkg::*; #(
  parameter int INST_BITS = 3
) (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Status sources
  input wire logic [15:0] oper_cond_in,
  input wire logic [15:0] ques_cond_in,
  input wire logic [7:0] std_event_in,
  input wire logic message_available_bit,
  input wire logic [INST_BITS-1:0] inst_status_in,
  // Command, poll and request
  input wire sesum_cmd_t cmd_in,
  input wire sesum_resp_t resp_r,
  input wire logic poll_rd,
  input wire sesum_poll_t poll_r,
  input wire logic request_service_flag
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);

  a_resp_next_cycle:
    assert property (cmd_in.valid |=> resp_r.valid) else $error("answer missing");
  a_resp_idle_zero:
    assert property (!cmd_in.valid |=> !resp_r.valid && resp_r.data == 16'h0000)
    else $error("idle answer not zero");
  a_hidden_std:
    assert property (cmd_in.valid && cmd_in.tgt == SESUM_TGT_COMMON && cmd_in.act inside
      {SESUM_ACT_COND_RD, SESUM_ACT_RISE_RD, SESUM_ACT_FALL_RD} |=> resp_r.error)
    else $error("hidden std register answered");
  a_cond_live_read:
    assert property (cmd_in.valid && cmd_in.tgt == SESUM_TGT_OPER && !$past(sys_rst) &&
      cmd_in.act == SESUM_ACT_COND_RD && $stable(oper_cond_in)
      |=> resp_r.data == ($past(oper_cond_in, 2) & 16'h7fff)) else $error("cond read wrong");
  a_std_enable_byte:
    assert property (cmd_in.valid && cmd_in.tgt == SESUM_TGT_COMMON &&
      cmd_in.act == SESUM_ACT_ENABLE_RD |=> resp_r.data[15:8] == 8'h00)
    else $error("std enable upper byte set");
  a_poll_rqs:
    assert property (poll_rd |=> poll_r.valid &&
      !(request_service_flag && $past(request_service_flag)) &&
      poll_r.data[SESUM_SB_RQS] == $past(request_service_flag)) else $error("poll flag bad");
  a_poll_mav:
    assert property (poll_rd && $stable(message_available_bit) |=>
      poll_r.data[SESUM_SB_MAV] == $past(message_available_bit)) else $error("poll bit 4 bad");
  a_poll_inst:
    assert property (poll_rd && $stable(inst_status_in) |=>
      poll_r.data[INST_BITS-1:0] == $past(inst_status_in)) else $error("poll bits 0-2 bad");
  a_flag_held:
    assert property (request_service_flag && !poll_rd |=> request_service_flag)
    else $error("flag dropped without poll");
  a_flag_poll_clear:
    assert property ($fell(request_service_flag) |-> $past(poll_rd))
    else $error("flag fell without poll");
  a_flag_rise_free:
    assert property ($rose(request_service_flag) |-> !poll_r.valid ||
      !poll_r.data[SESUM_SB_RQS]) else $error("poll claimed a new request");

  c_flag_raised: cover property ($rose(request_service_flag));
  c_poll_flag: cover property (poll_rd && request_service_flag);
  c_event_read: cover property (cmd_in.valid && cmd_in.act == SESUM_ACT_EVENT_RD);
endmodule : sesum_checker

bind sesum_top sesum_checker #(.INST_BITS(INST_BITS)) u_checker (.clock(clock),
  .sys_rst(sys_rst), .oper_cond_in(oper_cond_in), .ques_cond_in(ques_cond_in),
  .std_event_in(std_event_in), .message_available_bit(message_available_bit),
  .inst_status_in(inst_status_in), .cmd_in(cmd_in), .resp_r(resp_r), .poll_rd(poll_rd),
  .poll_r(poll_r), .request_service_flag(request_service_flag));

// >>> verif/sesum_top_tb.sv
// Self-checking testbench of the status event summary block
`timescale 1ns/1ps
module sesum_top_tb import sesum_pkg::*; ;
  localparam sesum_tgt_t CM = SESUM_TGT_COMMON;
  localparam sesum_tgt_t OP = SESUM_TGT_OPER;
  localparam sesum_tgt_t QU = SESUM_TGT_QUES;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic [15:0] oper_cond_in = 16'h0000;
  logic [15:0] ques_cond_in = 16'h0000;
  logic [7:0] std_event_in = 8'h00;
  logic message_available_bit = 1'b0;
  logic [2:0] inst_status_in = 3'h0;
  sesum_cmd_t cmd_in = '0;
  sesum_resp_t resp_r;
  logic poll_rd;
  sesum_poll_t poll_r;
  logic request_service_flag;
  logic [7:0] last_stb;
  int poll_count;
  logic [15:0] rd;
  logic re;
  int fails = 0;
  int cmp_count = 0;

  always #50 clock = ~clock;

  sesum_top dut_u (.clock(clock), .sys_rst(sys_rst), .oper_cond_in(oper_cond_in),
    .ques_cond_in(ques_cond_in), .std_event_in(std_event_in),
    .message_available_bit(message_available_bit), .inst_status_in(inst_status_in),
    .cmd_in(cmd_in), .resp_r(resp_r), .poll_rd(poll_rd), .poll_r(poll_r),
    .request_service_flag(request_service_flag));
  sesum_ctrl_model #(.POLL_DELAY(10)) ctrl_u (.clock(clock), .sys_rst(sys_rst),
    .request_service_flag(request_service_flag), .poll_r(poll_r), .poll_rd(poll_rd),
    .last_stb(last_stb), .poll_count(poll_count));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : step

  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check

  task automatic cmd(input sesum_tgt_t t, input sesum_act_t a, input logic [15:0] d);
    cmd_in = '{1'b1, t, a, d};
    step(1);
    rd = resp_r.data;
    re = resp_r.error;
    cmd_in = '0;
    step(1);
  endtask : cmd

  task automatic wait_poll();
    int n;
    n = poll_count;
    for (int i = 0; i < 40 && poll_count == n; i++) step(1);
    check({15'h0000, poll_count != n}, 16'h0001, "poll seen");
  endtask : wait_poll

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_defaults();
    cmd(OP, SESUM_ACT_RISE_RD, 16'h0000);
    check(rd, 16'h7fff, "rise default");
    cmd(OP, SESUM_ACT_FALL_RD, 16'h0000);
    check(rd, 16'h0000, "fall default");
    cmd(CM, SESUM_ACT_RISE_RD, 16'h0000);
    check({15'h0000, re}, 16'h0001, "std filter hidden");
    cmd(CM, SESUM_ACT_COND_RD, 16'h0000);
    check({15'h0000, re}, 16'h0001, "std cond hidden");
  endtask : t_defaults

  task automatic t_filters();
    cmd(OP, SESUM_ACT_RISE_WR, 16'h0009);
    cmd(OP, SESUM_ACT_FALL_WR, 16'h800a);
    cmd(OP, SESUM_ACT_FALL_RD, 16'h0000);
    check(rd, 16'h000a, "fall readback");
    oper_cond_in = 16'h000f;
    step(2);
    cmd(OP, SESUM_ACT_COND_RD, 16'h0000);
    check(rd, 16'h000f, "condition");
    cmd(OP, SESUM_ACT_EVENT_RD, 16'h0000);
    check(rd, 16'h0009, "rising events");
    oper_cond_in = 16'h0000;
    step(2);
    cmd(OP, SESUM_ACT_EVENT_RD, 16'h0000);
    check(rd, 16'h000a, "falling events");
    cmd(CM, SESUM_ACT_CLS, 16'h0000);
    cmd(OP, SESUM_ACT_RISE_RD, 16'h0000);
    check(rd, 16'h0009, "filter after clear");
    cmd(CM, SESUM_ACT_RST, 16'h0000);
    cmd(OP, SESUM_ACT_RISE_RD, 16'h0000);
    check(rd, 16'h7fff, "filter after reset cmd");
  endtask : t_filters

  task automatic t_latch();
    oper_cond_in = 16'h0001;
    step(1);
    oper_cond_in = 16'h0000;
    step(1);
    oper_cond_in = 16'h0001;
    step(2);
    cmd(OP, SESUM_ACT_EVENT_RD, 16'h0000);
    check(rd, 16'h0001, "latched");
    cmd(OP, SESUM_ACT_EVENT_RD, 16'h0000);
    check(rd, 16'h0000, "no queued event");
    oper_cond_in = 16'h0000;
    step(2);
    oper_cond_in = 16'h0001;
    cmd(OP, SESUM_ACT_EVENT_RD, 16'h0000);
    cmd(OP, SESUM_ACT_EVENT_RD, 16'h0000);
    check(rd, 16'h0001, "coincident event kept");
    cmd(OP, SESUM_ACT_ENABLE_WR, 16'h0004);
    oper_cond_in = 16'h0000;
    step(1);
    oper_cond_in = 16'h0001;
    step(2);
    cmd(CM, SESUM_ACT_CLS, 16'h0000);
    cmd(OP, SESUM_ACT_EVENT_RD, 16'h0000);
    check(rd, 16'h0000, "cleared by clear");
    cmd(OP, SESUM_ACT_ENABLE_RD, 16'h0000);
    check(rd, 16'h0004, "enable kept");
  endtask : t_latch

  task automatic t_srq();
    cmd(CM, SESUM_ACT_ENABLE_WR, 16'd48);
    cmd(CM, SESUM_ACT_ENABLE_RD, 16'h0000);
    check(rd, 16'h0030, "std enable");
    cmd(CM, SESUM_ACT_SRE_WR, 16'h0020);
    std_event_in = 8'h04;
    step(3);
    check({15'h0000, request_service_flag}, 16'h0000, "query err masked");
    std_event_in = 8'h14;
    step(2);
    check({15'h0000, request_service_flag}, 16'h0001, "request raised");
    cmd(CM, SESUM_ACT_STB_RD, 16'h0000);
    check(rd, 16'h0060, "status query");
    check({15'h0000, request_service_flag}, 16'h0001, "query keeps flag");
    wait_poll();
    check({8'h00, last_stb}, 16'h0060, "poll byte");
    step(15);
    check({15'h0000, request_service_flag}, 16'h0000, "no re-raise");
    cmd(QU, SESUM_ACT_CLS, 16'h0000);
    check({15'h0000, re}, 16'h0001, "refused clear");
    cmd(CM, SESUM_ACT_EVENT_RD, 16'h0000);
    check(rd, 16'h0014, "std events");
    std_event_in = 8'h34;
    step(2);
    check({15'h0000, request_service_flag}, 16'h0001, "new request");
    wait_poll();
  endtask : t_srq

  task automatic t_byte();
    cmd(CM, SESUM_ACT_EVENT_RD, 16'h0000);
    cmd(QU, SESUM_ACT_ENABLE_WR, 16'h0001);
    cmd(OP, SESUM_ACT_ENABLE_WR, 16'h4000);
    cmd(CM, SESUM_ACT_SRE_WR, 16'h00ff);
    cmd(CM, SESUM_ACT_SRE_RD, 16'h0000);
    check(rd, 16'h00bf, "request enable");
    ques_cond_in = 16'h8001;
    oper_cond_in = 16'h4001;
    message_available_bit = 1'b1;
    inst_status_in = 3'h5;
    step(2);
    cmd(CM, SESUM_ACT_STB_RD, 16'h0000);
    check(rd, 16'h00dd, "status byte bits");
    cmd(QU, SESUM_ACT_COND_RD, 16'h0000);
    check(rd, 16'h0001, "bit 15 zero");
    wait_poll();
    check({8'h00, last_stb}, 16'h00dd, "poll matches query");
  endtask : t_byte

  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    step(20);
    sys_rst = 1'b0;
    t_defaults();
    t_filters();
    t_latch();
    t_srq();
    t_byte();
    print_verdict();
  end

  initial begin
    repeat (3000) @(posedge clock);
    fails++;
    print_verdict();
  end
endmodule : sesum_top_tb
